//--- hw/smsc_map.svh
// Constants for the slave memory control: widths, decode fields, timing.
// Assumes inclusion by the package and the control module.
`ifndef SMSC_MAP_SVH
`define SMSC_MAP_SVH
`define SMSC_CLK_MHZ 20
`define SMSC_ACC_NS 250
`define SMSC_ACC_CYC ((`SMSC_ACC_NS * `SMSC_CLK_MHZ + 999) / 1000)
`define SMSC_CNT_W 4
`define SMSC_AW 18
`define SMSC_DW 16
`define SMSC_DEC_HI 17
`define SMSC_DEC_LO 13
`define SMSC_MAD_W 15
`define SMSC_NMOD 4
`define SMSC_SW_W 4
`define SMSC_WIDX_W 12
`define SMSC_MIDX_W 14
`define SMSC_NWORDS 16384
`define SMSC_DATA_RST 16'h0000
`define SMSC_MAD_RST 15'h0000
`endif

//--- hw/smsc_pkg.sv
// Types for the slave memory control.
// Assumes smsc_map.svh is on the include path.
`include "smsc_map.svh"
package smsc_pkg;
    typedef enum logic [1:0] {
        CYC_READ       = 2'b00,
        CYC_READ_PAUSE = 2'b01,
        CYC_WRITE_WORD = 2'b10,
        CYC_WRITE_BYTE = 2'b11
    } smsc_cycle_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ   = 3'b001,
        ST_PROG  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_READY = 3'b100,
        ST_SYNC  = 3'b101
    } smsc_state_t;
    typedef enum logic [1:0] {
        MT_BIP4K = 2'b00,
        MT_BIP1K = 2'b01,
        MT_MOS4K = 2'b10,
        MT_NONE  = 2'b11
    } smsc_mtype_t;
    typedef struct packed {
        logic [`SMSC_AW-1:0] addr;
        smsc_cycle_t         cyc;
        logic [`SMSC_DW-1:0] wdata;
    } smsc_req_t;
    typedef struct packed {
        logic [4:0]  match;
        logic [4:0]  care;
        logic        map_b12;
        smsc_mtype_t mtype;
    } smsc_jmp_t;
endpackage

//--- hw/smsc_ctrl.sv
// Slave memory control: decode, arbitration, timing and matrix store.
// Assumes bus and fast port inputs are synchronous to CLK.
`timescale 1ns/10ps
`include "smsc_map.svh"
module smsc_ctrl (
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire smsc_pkg::smsc_req_t  BUS_REQ,
    input  wire logic                 BUS_MSYNC,
    output logic                      BUS_SLAVE_SYNC_OUT,
    output logic [`SMSC_DW-1:0]       BUS_RDATA,
    output logic                      BUS_DATA_OE_N,
    input  wire logic                 FP_REQ_VALID,
    input  wire smsc_pkg::smsc_req_t  FP_REQ,
    output logic                      FP_DONE,
    output logic [`SMSC_DW-1:0]       FP_RDATA,
    input  wire smsc_pkg::smsc_jmp_t  JUMPERS,
    input  wire logic [15:0]          MOD_SW,
    output logic                      BUS_SIDE_REQUEST,
    output logic                      BUS_REQUEST_IN_PROGRESS,
    output logic                      INTERNAL_SLAVE_SYNC,
    output logic                      DATA_LATCH,
    output logic                      WRITE_PULSE,
    output logic                      READ_OUTPUT_LATCH_FLAG,
    output logic [`SMSC_MAD_W-1:0]    MEMORY_ADDRESS_REGISTER,
    output logic [`SMSC_DW-1:0]       WRITE_DATA_REG,
    output logic [`SMSC_NMOD-1:0]     MOD_SELECT
);
    localparam int ACC_CYC = `SMSC_ACC_CYC;

    smsc_pkg::smsc_state_t   state_ff, nxt_state;
    smsc_pkg::smsc_req_t     req_ff, nxt_req;
    logic [`SMSC_CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic                    owner_ff, nxt_owner;
    logic                    prog_ff, nxt_prog;
    logic                    older_ff, nxt_older;
    logic                    sa_ff, nxt_sa;
    logic [`SMSC_MAD_W-1:0]  mad_ff, nxt_mad;
    logic [`SMSC_DW-1:0]     rdata_ff, nxt_rdata;
    logic [`SMSC_DW-1:0]     wdata_ff, nxt_wdata;
    logic [`SMSC_DW-1:0]     mem_q [0:`SMSC_NWORDS-1];
    logic [`SMSC_DW-1:0]     mem_rd, mem_wd;
    logic                    mem_we, hit_any, is_wr;
    logic [`SMSC_MIDX_W-1:0] mem_idx;
    logic [`SMSC_WIDX_W-1:0] widx;
    logic [1:0]              mod_num;
    logic                    bus_live, fp_live, busy;

    // Jumper compare on bits 17:13; cut jumper means don't care
    function automatic logic dec_ok(input logic [`SMSC_AW-1:0] a);
        logic [4:0] d;
        d = a[`SMSC_DEC_HI:`SMSC_DEC_LO];
        return &(~(d ^ JUMPERS.match) | ~JUMPERS.care);
    endfunction

    // Shift 12:2 down one place, bit 12 of map by jumper
    function automatic logic [`SMSC_MAD_W-1:0] map_addr(
        input logic [`SMSC_AW-1:0] a);
        logic b12;
        b12 = JUMPERS.map_b12 ? a[12] : a[1];
        return {a[14:13], b12, a[12:2], a[0]};
    endfunction

    assign busy     = (state_ff != smsc_pkg::ST_IDLE);
    // Selection only once master sync is present
    assign bus_live = BUS_MSYNC & dec_ok(BUS_REQ.addr)
                      & ~(busy & ~owner_ff);
    assign fp_live  = FP_REQ_VALID & dec_ok(FP_REQ.addr)
                      & ~(busy & owner_ff);
    assign is_wr    = req_ff.cyc[1];

    // Sequencer and arbiter
    always_comb begin
        nxt_state = state_ff;
        nxt_req   = req_ff;
        nxt_cnt   = cnt_ff;
        nxt_owner = owner_ff;
        nxt_prog  = prog_ff;
        nxt_sa    = sa_ff;
        nxt_mad   = mad_ff;
        nxt_rdata = rdata_ff;
        nxt_wdata = wdata_ff;
        // Fast port turns older while bus is absent, stays older while it is live
        nxt_older = fp_live & (older_ff | ~bus_live);
        case (state_ff)
            smsc_pkg::ST_IDLE: begin
                nxt_prog = 1'b0;
                if (bus_live && (!fp_live || !older_ff)) begin
                    nxt_owner = 1'b0;
                    nxt_req   = BUS_REQ;
                    nxt_state = smsc_pkg::ST_REQ;
                end else if (fp_live) begin
                    nxt_owner = 1'b1;
                    nxt_req   = FP_REQ;
                    nxt_state = smsc_pkg::ST_REQ;
                end
            end
            smsc_pkg::ST_REQ: begin
                nxt_prog  = 1'b1;
                nxt_state = smsc_pkg::ST_PROG;
            end
            smsc_pkg::ST_PROG: begin
                nxt_mad   = map_addr(req_ff.addr);
                nxt_cnt   = `SMSC_CNT_W'(ACC_CYC - 1);
                nxt_state = smsc_pkg::ST_WAIT;
            end
            smsc_pkg::ST_WAIT: begin
                if (cnt_ff == '0) begin
                    nxt_state = smsc_pkg::ST_READY;
                end else begin
                    nxt_cnt = cnt_ff - `SMSC_CNT_W'(1);
                end
            end
            smsc_pkg::ST_READY: begin
                if (is_wr) begin
                    nxt_wdata = req_ff.wdata;
                end else begin
                    nxt_rdata = mem_rd;
                end
                if (!owner_ff) begin
                    nxt_sa = 1'b0;
                end
                nxt_state = smsc_pkg::ST_SYNC;
            end
            smsc_pkg::ST_SYNC: begin
                if (owner_ff) begin
                    nxt_sa    = ~is_wr;
                    nxt_state = smsc_pkg::ST_IDLE;
                end else if (!BUS_MSYNC) begin
                    nxt_state = smsc_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = smsc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_ff <= smsc_pkg::ST_IDLE;
            req_ff   <= '0;
            cnt_ff   <= '0;
            owner_ff <= 1'b0;
            prog_ff  <= 1'b0;
            older_ff <= 1'b0;
            sa_ff    <= 1'b0;
            mad_ff   <= `SMSC_MAD_RST;
            rdata_ff <= `SMSC_DATA_RST;
            wdata_ff <= `SMSC_DATA_RST;
        end else begin
            state_ff <= nxt_state;
            req_ff   <= nxt_req;
            cnt_ff   <= nxt_cnt;
            owner_ff <= nxt_owner;
            prog_ff  <= nxt_prog;
            older_ff <= nxt_older;
            sa_ff    <= nxt_sa;
            mad_ff   <= nxt_mad;
            rdata_ff <= nxt_rdata;
            wdata_ff <= nxt_wdata;
        end
    end

    // Matrix module selection, one per module slot
    genvar gi;
    generate
        for (gi = 0; gi < `SMSC_NMOD; gi++) begin : g_mod
            logic [3:0] sw;
            assign sw = MOD_SW[gi*`SMSC_SW_W +: `SMSC_SW_W];
            always_comb begin
                case (JUMPERS.mtype)
                    smsc_pkg::MT_BIP4K:
                        MOD_SELECT[gi] = mad_ff[14:13] == sw[3:2];
                    smsc_pkg::MT_BIP1K:
                        MOD_SELECT[gi] = {mad_ff[14:13], mad_ff[11:10]}
                                         == sw;
                    smsc_pkg::MT_MOS4K:
                        MOD_SELECT[gi] = mad_ff[14:13] == sw[3:2];
                    default:
                        MOD_SELECT[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Row and word inside the chosen module
    always_comb begin
        case (JUMPERS.mtype)
            smsc_pkg::MT_BIP4K:
                widx = {mad_ff[11:10], mad_ff[12], mad_ff[9:1]};
            smsc_pkg::MT_BIP1K:
                widx = {2'b00, mad_ff[9:8], mad_ff[12], mad_ff[7:1]};
            smsc_pkg::MT_MOS4K:
                widx = {mad_ff[2:1], mad_ff[12:3]};
            default:
                widx = '0;
        endcase
        mod_num = MOD_SELECT[0] ? 2'h0 : MOD_SELECT[1] ? 2'h1 :
                  MOD_SELECT[2] ? 2'h2 : 2'h3;
    end

    assign hit_any = |MOD_SELECT;
    assign mem_idx = {mod_num, widx};

    // Write merge; odd address with byte write hits the high byte
    always_comb begin
        mem_rd = hit_any ? mem_q[mem_idx] : `SMSC_DATA_RST;
        mem_wd = req_ff.wdata;
        if (req_ff.cyc == smsc_pkg::CYC_WRITE_BYTE) begin
            mem_wd = mad_ff[0] ? {req_ff.wdata[15:8], mem_rd[7:0]}
                               : {mem_rd[15:8], req_ff.wdata[7:0]};
        end
        mem_we = WRITE_PULSE & hit_any;
    end

    always_ff @(posedge CLK) begin
        if (mem_we) begin
            mem_q[mem_idx] <= mem_wd;
        end
    end

    // Strobe, write pulse and internal sync share the ready step
    assign DATA_LATCH  = (state_ff == smsc_pkg::ST_READY) & prog_ff
                         & is_wr;
    assign WRITE_PULSE = DATA_LATCH;
    assign INTERNAL_SLAVE_SYNC = prog_ff & ((state_ff == smsc_pkg::ST_READY)
                         | (state_ff == smsc_pkg::ST_SYNC));
    assign BUS_SLAVE_SYNC_OUT = (state_ff == smsc_pkg::ST_SYNC) & prog_ff
                         & ~owner_ff;
    assign BUS_DATA_OE_N = ~(BUS_SLAVE_SYNC_OUT & ~is_wr);
    assign FP_DONE     = (state_ff == smsc_pkg::ST_SYNC) & owner_ff;
    assign BUS_RDATA   = rdata_ff;
    assign FP_RDATA    = rdata_ff;
    assign BUS_SIDE_REQUEST        = (state_ff == smsc_pkg::ST_REQ)
                                     & ~owner_ff;
    assign BUS_REQUEST_IN_PROGRESS = prog_ff;
    assign READ_OUTPUT_LATCH_FLAG  = sa_ff;
    assign MEMORY_ADDRESS_REGISTER = mad_ff;
    assign WRITE_DATA_REG          = wdata_ff;

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_wait_run;
        (state_ff == smsc_pkg::ST_WAIT) [*5];
    endsequence
    sequence s_ready;
        state_ff == smsc_pkg::ST_READY;
    endsequence

    AST_NO_SELECT: assert property (
        (!busy && BUS_MSYNC && !dec_ok(BUS_REQ.addr) && !fp_live)
        |=> !busy)
        else $error("Unselected address started a cycle");
    AST_MSYNC_GATE: assert property (
        (!busy && !BUS_MSYNC) |=> !BUS_SIDE_REQUEST)
        else $error("Bus request without master sync");
    AST_IN_PROG: assert property (
        (state_ff == smsc_pkg::ST_REQ) |=> prog_ff [*2])
        else $error("In-progress flag not set after request");
    AST_MAD_FIRST: assert property (
        (state_ff == smsc_pkg::ST_PROG) |=>
        (mad_ff == map_addr(req_ff.addr)) && !DATA_LATCH)
        else $error("Address register not loaded before strobe");
    AST_DELAY: assert property (
        (state_ff == smsc_pkg::ST_PROG) |=> s_wait_run ##1 s_ready)
        else $error("Access ready delay wrong");
    AST_STROBE_SYNC: assert property (
        DATA_LATCH |-> INTERNAL_SLAVE_SYNC && WRITE_PULSE)
        else $error("Strobe without internal sync");
    AST_WDATA: assert property (
        DATA_LATCH |=> wdata_ff == $past(req_ff.wdata))
        else $error("Write data register not loaded");
    AST_SSYNC_HOLD: assert property (
        (BUS_SLAVE_SYNC_OUT && BUS_MSYNC) |=> BUS_SLAVE_SYNC_OUT)
        else $error("Slave sync dropped before master sync");
    AST_IDLE_AFTER: assert property (
        (BUS_SLAVE_SYNC_OUT && !BUS_MSYNC) |=>
        !BUS_SLAVE_SYNC_OUT && !busy)
        else $error("Not idle after master sync removal");
    AST_READ_DRIVE: assert property (
        (BUS_SLAVE_SYNC_OUT && !is_wr) |-> !BUS_DATA_OE_N)
        else $error("Read data not driven with slave sync");
    AST_READ_SYNC: assert property (
        $rose(BUS_SLAVE_SYNC_OUT) |->
        $past(state_ff == smsc_pkg::ST_READY) && !READ_OUTPUT_LATCH_FLAG)
        else $error("Read slave sync too early");
    AST_TIE: assert property (
        (!busy && bus_live && fp_live && !older_ff) |=>
        !owner_ff && state_ff == smsc_pkg::ST_REQ)
        else $error("Tie not granted to system bus");
    AST_ORDER: assert property (
        (!busy && fp_live && older_ff) |=> owner_ff)
        else $error("Older fast port request passed over");
    AST_LOCK: assert property (
        (busy && nxt_state != smsc_pkg::ST_IDLE) |=>
        $stable(owner_ff) && $stable(req_ff))
        else $error("Running cycle was disturbed");
    AST_FP_DATA: assert property (
        (FP_DONE && !is_wr) |->
        FP_RDATA == $past(mem_rd) && BUS_RDATA == FP_RDATA)
        else $error("Read data not routed to both ports");
endmodule // smsc_ctrl

//--- tb/smsc_bus_master.sv
// Bus master model for the slave memory control: one access per call.
// Assumes each call starts just after a rising edge of clk.
`timescale 1ns/10ps
module smsc_bus_master (
    input  wire logic           clk,
    input  wire logic           ssync,
    input  wire logic [15:0]    rdata,
    input  wire logic           oe_n,
    output smsc_pkg::smsc_req_t req,
    output logic                msync
);
    initial begin
        req = '0;
        msync = 1'b0;
    end
    // Edges to slave sync in n, 0 if none came
    task automatic cycle(input smsc_pkg::smsc_req_t r, input int hold,
        output int n, output logic [15:0] d, output logic oe);
        n = 0;
        d = 16'h0000;
        oe = 1'b1;
        if (!r.cyc[1]) begin
            r.wdata = ~req.wdata;
        end
        req = r;
        @(posedge clk);
        #1 msync = 1'b1;
        for (int k = 1; k <= 20 && n == 0; k++) begin
            @(posedge clk);
            #1;
            if (ssync === 1'b1) begin
                n = k;
                d = rdata;
                oe = oe_n;
            end
        end
        repeat (hold + 1) begin
            @(posedge clk);
            #1;
        end
        msync = 1'b0;
        req = smsc_pkg::smsc_req_t'(~req);
    endtask
endmodule // smsc_bus_master

//--- tb/tb_smsc_ctrl.sv
// Self-checking bench for the slave memory control.
// Assumes the package, design and bus master model compile first.
`timescale 1ns/10ps
module tb_smsc_ctrl;
    logic                clk;
    logic                rst;
    smsc_pkg::smsc_req_t bq;
    logic                ms;
    logic                ss;
    logic [15:0]         brd;
    logic                oe_n;
    logic                fv;
    smsc_pkg::smsc_req_t fq;
    logic                fd;
    logic [15:0]         frd;
    smsc_pkg::smsc_jmp_t jmp;
    logic [15:0]         msw;
    logic                rof;
    logic [14:0]         memory_address_register;
    logic [15:0]         wdr;
    logic [3:0]          sel;
    logic                data_on;
    int                  num_errors;
    int                  total_checks;
    integer              seed;
    logic [15:0]         mem [int];
    smsc_ctrl DUT (.CLK(clk), .RESET(rst), .BUS_REQ(bq), .BUS_MSYNC(ms),
        .BUS_SLAVE_SYNC_OUT(ss), .BUS_RDATA(brd), .BUS_DATA_OE_N(oe_n),
        .FP_REQ_VALID(fv), .FP_REQ(fq), .FP_DONE(fd), .FP_RDATA(frd),
        .JUMPERS(jmp), .MOD_SW(msw), .BUS_SIDE_REQUEST(),
        .BUS_REQUEST_IN_PROGRESS(), .INTERNAL_SLAVE_SYNC(),
        .DATA_LATCH(), .WRITE_PULSE(), .READ_OUTPUT_LATCH_FLAG(rof),
        .MEMORY_ADDRESS_REGISTER(memory_address_register), .WRITE_DATA_REG(wdr),
        .MOD_SELECT(sel));
    smsc_bus_master master (.clk(clk), .ssync(ss), .rdata(brd),
        .oe_n(oe_n), .req(bq), .msync(ms));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic hit(logic [17:0] a);
        return ((a[17:13] ^ jmp.match) & jmp.care) == 5'h00;
    endfunction
    function automatic logic [14:0] xmad(logic [17:0] a);
        return {a[14:13], jmp.map_b12 ? a[12] : a[1], a[12:2], a[0]};
    endfunction
    function automatic logic [3:0] xsel(logic [14:0] m);
        logic [3:0] s;
        for (int i = 0; i < 4; i++) begin
            s[i] = msw[4*i+2 +: 2] == m[14:13];
            if (jmp.mtype == smsc_pkg::MT_BIP1K)
                s[i] = s[i] && msw[4*i +: 2] == m[11:10];
            if (jmp.mtype == smsc_pkg::MT_NONE)
                s[i] = 1'b0;
        end
        return s;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m,
                got, exp);
        end
    endtask
    task automatic bus(logic [17:0] a, smsc_pkg::smsc_cycle_t c,
        logic [15:0] w, int hold);
        int n;
        logic [15:0] d;
        logic oe;
        logic [15:0] e;
        master.cycle('{addr: a, cyc: c, wdata: w}, hold, n, d, oe);
        e = mem.exists(a[14:1]) ? mem[a[14:1]] : 16'h0000;
        if (!hit(a)) begin
            chk(16'(n), 16'h0000, "stray reply");
        end else begin
            chk(16'(n), 16'h0009, "sync delay");
            chk({1'b0, memory_address_register}, {1'b0, xmad(a)}, "map");
            chk({12'h000, sel}, {12'h000, xsel(xmad(a))}, "sel");
            chk({15'h0000, oe}, {15'h0000, c[1]}, "drive");
            if (data_on && c[1]) begin
                if (c == smsc_pkg::CYC_WRITE_WORD)
                    e = w;
                else if (a[0])
                    e[15:8] = w[15:8];
                else
                    e[7:0] = w[7:0];
                mem[a[14:1]] = e;
                if (c == smsc_pkg::CYC_WRITE_WORD)
                    chk(wdr, w, "wdata reg");
            end else if (data_on) begin
                chk(d, e, "read data");
                chk({15'h0000, rof}, 16'h0000, "out latch");
            end
        end
        if (hold > 0)
            chk({15'h0000, ss}, 16'h0001, "sync held");
        @(posedge clk);
        #1;
        chk({14'h0000, ss, oe_n}, 16'h0001, "idle");
    endtask
    task automatic fp(logic [17:0] a, output int n, output logic [15:0] d);
        n = 0;
        d = 16'h0000;
        fq = '{addr: a, cyc: smsc_pkg::CYC_READ, wdata: 16'h5a5a};
        @(posedge clk);
        #1 fv = 1'b1;
        for (int k = 1; k <= 40 && n == 0; k++) begin
            @(posedge clk);
            #1;
            if (fd === 1'b1) begin
                n = k;
                d = frd;
            end
        end
        @(posedge clk);
        #1;
        fv = 1'b0;
        fq = smsc_pkg::smsc_req_t'(~fq);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
    initial begin
        logic [17:0] a;
        int n;
        int k;
        logic [15:0] d;
        logic [15:0] d2;
        logic oe;
        seed = 32'hc1a6167a;
        rst = 1'b1;
        fv = 1'b0;
        fq = '0;
        jmp = '0;
        msw = 16'hc840;
        data_on = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 24; i++) begin
            jmp = smsc_pkg::smsc_jmp_t'(13'($random(seed)));
            jmp.mtype = smsc_pkg::smsc_mtype_t'(i % 4);
            msw = 16'($random(seed));
            a = 18'($random(seed));
            if (i % 2 == 0)
                a[17:13] = jmp.match;
            bus(a, smsc_pkg::smsc_cycle_t'((i / 4) % 2), 16'h0000, 0);
        end
        jmp = '{match: 5'h14, care: 5'h1c, map_b12: 1'b0,
            mtype: smsc_pkg::MT_MOS4K};
        msw = 16'hc840;
        data_on = 1'b1;
        // Fill every word the data scenarios reach
        for (int j = 0; j < 32; j++) begin
            a = {3'h5, j[4:3], 9'h000, j[2:0], 1'b0};
            bus(a, smsc_pkg::CYC_WRITE_WORD, 16'($random(seed)), 0);
        end
        bus(18'h2a006, smsc_pkg::CYC_WRITE_WORD, 16'h1234, 0);
        bus(18'h2a007, smsc_pkg::CYC_WRITE_BYTE, 16'hab00, 1);
        bus(18'h2a006, smsc_pkg::CYC_WRITE_BYTE, 16'h00cd, 0);
        bus(18'h0a006, smsc_pkg::CYC_WRITE_WORD, 16'hffff, 0);
        bus(18'h2a006, smsc_pkg::CYC_READ_PAUSE, 16'h0000, 2);
        for (int i = 0; i < 40; i++) begin
            a = {3'h5, 15'($random(seed)) & 15'h600f};
            bus(a, smsc_pkg::smsc_cycle_t'(2'($random(seed))),
                16'($random(seed)), {$random(seed)} % 3);
        end
        fork
            master.cycle('{addr: 18'h2a006, cyc: smsc_pkg::CYC_READ,
                wdata: 16'h0000}, 0, n, d, oe);
            fp(18'h2a006, k, d2);
        join
        chk(16'(n), 16'h0009, "tie bus");
        chk({15'h0000, k > 9}, 16'h0001, "tie fast");
        chk(d2, mem[13'h1003], "fast data");
        @(posedge clk);
        #1;
        fork
            fp(18'h2a006, k, d2);
            begin
                @(posedge clk);
                #1;
                master.cycle('{addr: 18'h2a006, cyc: smsc_pkg::CYC_READ,
                    wdata: 16'h0000}, 0, n, d, oe);
            end
        join
        chk(16'(k), 16'h0009, "first fast");
        chk({15'h0000, n > 9}, 16'h0001, "later bus");
        chk(d, mem[13'h1003], "bus data");
        chk({15'h0000, rof}, 16'h0000, "latch clear");
        print_verdict();
    end
endmodule // tb_smsc_ctrl
